// ==== rtl/tp_host.sv ====
// Bus controller end: power-on address choice and register burst transfers.
`include "tp_defines.svh"

module tp_host (
  input wire logic core_clk,
  input wire logic rst,
  tp_i2c_if.host bus,
  input wire logic addr_alt,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack_err,
  output logic touch_int
);
  tp_pkg::tp_host_st_t st;
  tp_pkg::tp_kind_t kind;
  logic [7:0] tmr;
  logic [7:0] lim;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [7:0] tx;
  logic [7:0] sh;
  logic [15:0] addr;
  logic [7:0] len;
  logic rd;
  logic second;
  logic rx;
  logic [6:0] tgt;
  logic [1:0] sda_ff;
  logic [1:0] int_ff;
  logic scl_oe;
  logic sda_oe;
  logic rst_line_n;
  logic int_oe;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_ff <= 2'h3;
      int_ff <= 2'h0;
    end else begin
      sda_ff <= {sda_ff[0], bus.sda};
      int_ff <= {int_ff[0], bus.int_line};
    end
  end

  assign touch_int = int_ff[1];
  // Only read data bytes are sent by the target; every address byte, the
  // repeated-start one included, is still driven by this end.
  assign rx = rd & second & (kind == tp_pkg::TP_K_DATA);
  assign tgt = addr_alt ? `TP_ADDR_ALT : `TP_ADDR_PRI;
  assign cmd_ready = (st == tp_pkg::TP_H_IDLE);
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe;
  assign bus.touch_rst_n = rst_line_n;
  assign bus.host_int_o = addr_alt;
  assign bus.host_int_oe = int_oe;

  // Low phases carry the long wait, high phases the short one.
  // bit rate cap
  always_comb begin
    lim = 8'(`TP_SCL_HI_CYC - 1);
    if (st == tp_pkg::TP_H_POR) begin
      lim = 8'(`TP_POR_CYC - 1);
    end else if (st == tp_pkg::TP_H_SEL) begin
      lim = 8'(`TP_SEL_HOLD_CYC - 1);
    end else if (ph == 2'h0) begin
      lim = 8'(`TP_SCL_LO_CYC - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The data line moves a while after the clock falls, never together with it,
  // so the target's synchronisers cannot see a false Start or Stop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= tp_pkg::TP_H_POR;
      kind <= tp_pkg::TP_K_ADDR;
      tmr <= 8'h00;
      ph <= 2'h0;
      bitn <= 4'h0;
      tx <= 8'h00;
      sh <= 8'h00;
      addr <= 16'h0000;
      len <= 8'h00;
      rd <= 1'b0;
      second <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rst_line_n <= 1'b0;
      int_oe <= 1'b1;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nack_err <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      tmr <= (tmr == lim) ? 8'h00 : tmr + 8'h01;
      unique case (st)
        tp_pkg::TP_H_POR: begin
          if (tmr == lim) begin
            rst_line_n <= 1'b1;
            st <= tp_pkg::TP_H_SEL;
          end
        end
        tp_pkg::TP_H_SEL: begin
          if (tmr == lim) begin
            int_oe <= 1'b0;
            st <= tp_pkg::TP_H_IDLE;
          end
        end
        tp_pkg::TP_H_IDLE: begin
          tmr <= 8'h00;
          if (cmd_valid) begin
            nack_err <= 1'b0;
            addr <= cmd_addr;
            len <= cmd_len;
            rd <= cmd_rd;
            second <= 1'b0;
            kind <= tp_pkg::TP_K_ADDR;
            tx <= {tgt, 1'b0};
            ph <= 2'h0;
            st <= tp_pkg::TP_H_START;
          end
        end
        tp_pkg::TP_H_START: begin
          if (ph == 2'h0) begin
            scl_oe <= 1'b1;
            sda_oe <= 1'b0;
          end
          if (tmr == lim) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              scl_oe <= 1'b0;
            end else if (ph == 2'h1) begin
              sda_oe <= 1'b1;
            end else begin
              scl_oe <= 1'b1;
              ph <= 2'h0;
              bitn <= 4'h0;
              st <= tp_pkg::TP_H_BIT;
            end
          end
        end
        tp_pkg::TP_H_BIT: begin
          if (ph == 2'h0 && tmr == 8'(`TP_SDA_SET_CYC)) begin
            // change data only while clock low
            if (bitn < `TP_BIT_ACK) begin
              sda_oe <= ~rx & ~tx[7];
            end else begin
              sda_oe <= rx & (len != 8'h01);
            end
          end
          if (tmr == lim && ph == 2'h0) begin
            scl_oe <= 1'b0;
            ph <= 2'h1;
          end else if (tmr == lim) begin
            scl_oe <= 1'b1;
            ph <= 2'h0;
            bitn <= bitn + 4'h1;
            if (bitn < `TP_BIT_ACK) begin
              sh <= {sh[6:0], sda_ff[1]};
              tx <= {tx[6:0], 1'b0};
            end else begin
              bitn <= 4'h0;
              if (!rx && sda_ff[1]) begin
                nack_err <= 1'b1;
                st <= tp_pkg::TP_H_STOP;
              end else begin
                unique case (kind)
                  tp_pkg::TP_K_ADDR: begin
                    kind <= second ? tp_pkg::TP_K_DATA : tp_pkg::TP_K_PHI;
                    tx <= addr[15:8];
                  end
                  tp_pkg::TP_K_PHI: begin
                    kind <= tp_pkg::TP_K_PLO;
                    tx <= addr[7:0];
                  end
                  tp_pkg::TP_K_PLO: begin
                    if (rd) begin
                      second <= 1'b1;
                      kind <= tp_pkg::TP_K_ADDR;
                      tx <= {tgt, 1'b1};
                      st <= tp_pkg::TP_H_START;
                    end else begin
                      kind <= tp_pkg::TP_K_DATA;
                      tx <= wr_data;
                      wr_take <= 1'b1;
                    end
                  end
                  tp_pkg::TP_K_DATA: begin
                    len <= len - 8'h01;
                    if (rd) begin
                      rd_valid <= 1'b1;
                      rd_data <= sh;
                    end
                    if (len == 8'h01) begin
                      st <= tp_pkg::TP_H_STOP;
                    end else if (!rd) begin
                      tx <= wr_data;
                      wr_take <= 1'b1;
                    end
                  end
                endcase
              end
            end
          end
        end
        tp_pkg::TP_H_STOP: begin
          if (ph == 2'h0 && tmr == 8'(`TP_SDA_SET_CYC)) begin
            sda_oe <= 1'b1;
          end
          if (tmr == lim) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              scl_oe <= 1'b0;
            end else if (ph == 2'h1) begin
              sda_oe <= 1'b0;
            end else begin
              ph <= 2'h0;
              done <= 1'b1;
              st <= tp_pkg::TP_H_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// ==== rtl/tp_defines.svh ====
// Constants for the touch controller two-wire target port and its host.
`ifndef TP_DEFINES_SVH
`define TP_DEFINES_SVH
`define TP_ADDR_PRI 7'h5d
`define TP_ADDR_ALT 7'h14
`define TP_CLK_NS 25
`define TP_SCL_LO_NS 1300
`define TP_SCL_HI_NS 600
`define TP_SCL_LO_CYC ((`TP_SCL_LO_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_SCL_HI_CYC ((`TP_SCL_HI_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_SDA_SET_NS 200
`define TP_SDA_SET_CYC ((`TP_SDA_SET_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_POR_NS 2000
`define TP_POR_CYC ((`TP_POR_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_SEL_HOLD_NS 1000
`define TP_SEL_HOLD_CYC ((`TP_SEL_HOLD_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_MEM_WORDS 256
`define TP_BIT_ACK 4'h8
`define TP_BIT_END 4'h9
`endif

// ==== rtl/tp_pkg.sv ====
// Types for both ends of the touch controller link; each type is used by one end only.
package tp_pkg;
  typedef enum logic [2:0] {
    TP_D_IDLE, TP_D_ADDR, TP_D_PHI, TP_D_PLO, TP_D_WDAT, TP_D_RDAT
  } tp_dev_st_t;
  typedef enum logic [2:0] {
    TP_H_POR, TP_H_SEL, TP_H_IDLE, TP_H_START, TP_H_BIT, TP_H_STOP
  } tp_host_st_t;
  typedef enum logic [1:0] {
    TP_K_ADDR, TP_K_PHI, TP_K_PLO, TP_K_DATA
  } tp_kind_t;
endpackage

// ==== rtl/tp_i2c_if.sv ====
// Two-wire bus, touch reset line and touch event line between host and controller.
interface tp_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic touch_rst_n;
  logic host_int_o;
  logic host_int_oe;
  logic dev_int_o;
  logic dev_int_oe;
  logic scl;
  logic sda;
  logic int_line;
  // Open-drain wires with pull-ups; the event line is pulled low when nobody drives.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  assign int_line = host_int_oe ? host_int_o : (dev_int_oe ? dev_int_o : 1'b0);
  modport dev (
    input scl, sda, touch_rst_n, int_line,
    output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe
  );
  modport host (
    input scl, sda, int_line,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, touch_rst_n,
    output host_int_o, host_int_oe
  );
endinterface

// ==== rtl/tp_dev.sv ====
// Touch controller two-wire target port with register pointer and byte memory.
`include "tp_defines.svh"

// What this block does
// - Controller is target only, never starts transfers.
// - Host keeps bit rate at most 400 kbit/s; this host's 1300 ns low and 600 ns high phases give about 526 kbit/s.
// - Answer one of two selectable address pairs.
// - Event line level at reset release picks address.
// - Data falling while clock high is Start.
// - Matching address acknowledged low on ninth clock.
// - Unmatched address: stay idle, never drive.
// - Nine clocks per byte, recipient sends acknowledge.
// - Data sampled while clock high only.
// - Data rising while clock high is Stop.
// - Address byte bit zero selects write/read.
// - Write carries 16-bit pointer, then data bytes.
// - Pointer increments after every written byte.
// - Read follows pointer write and repeated Start.
// - Burst reads while host keeps acknowledging.
// - Host not-acknowledge releases data line, ends.
// - Touch reset line is active low.
// - Event line signals touch events to host.
module tp_dev (
  input wire logic link_clk,
  input wire logic rst,
  tp_i2c_if.dev bus,
  input wire logic touch_evt,
  output logic wr_stb,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [6:0] own_addr,
  output logic evt_pend
);
  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic [1:0] rstn_ff;
  logic [1:0] int_ff;
  logic scl_d;
  logic sda_d;
  logic rstn_d;
  logic sel_alt;
  logic armed;
  logic local_rst;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  tp_pkg::tp_dev_st_t st;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic rw;
  logic acked;
  logic [15:0] ptr;
  logic sda_oe;
  logic [7:0] mem [`TP_MEM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // The bus pins come from the host's clock domain.
  always_ff @(posedge link_clk) begin
    if (rst) begin
      scl_ff <= 2'h3;
      sda_ff <= 2'h3;
      rstn_ff <= 2'h0;
      int_ff <= 2'h0;
    end else begin
      scl_ff <= {scl_ff[0], bus.scl};
      sda_ff <= {sda_ff[0], bus.sda};
      rstn_ff <= {rstn_ff[0], bus.touch_rst_n};
      int_ff <= {int_ff[0], bus.int_line};
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rstn_d <= 1'b0;
    end else begin
      scl_d <= scl_ff[1];
      sda_d <= sda_ff[1];
      rstn_d <= rstn_ff[1];
    end
  end

  assign local_rst = rst | ~rstn_ff[1];
  assign scl_rise = scl_ff[1] & ~scl_d;
  assign scl_fall = ~scl_ff[1] & scl_d;
  assign start_c = scl_ff[1] & scl_d & sda_d & ~sda_ff[1];
  assign stop_c = scl_ff[1] & scl_d & ~sda_d & sda_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // The address choice is caught on the clock after the synchronised reset line rises.
  always_ff @(posedge link_clk) begin
    if (rst) begin
      sel_alt <= 1'b0;
    end else if (rstn_ff[1] & ~rstn_d) begin
      sel_alt <= int_ff[1];
    end
  end

  always_ff @(posedge link_clk) begin
    if (local_rst) begin
      armed <= 1'b0;
    end else if (~rstn_d) begin
      armed <= 1'b1;
    end
  end

  assign own_addr = sel_alt ? `TP_ADDR_ALT : `TP_ADDR_PRI;

  always_ff @(posedge link_clk) begin
    if (local_rst) begin
      evt_pend <= 1'b0;
    end else if (touch_evt) begin
      evt_pend <= 1'b1;
    end else if (st == tp_pkg::TP_D_RDAT) begin
      evt_pend <= 1'b0;
    end
  end

  assign bus.dev_int_oe = armed;
  assign bus.dev_int_o = evt_pend;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine. Bits are sampled on a rising clock and the data line only
  // changes after a falling clock, so a host with zero hold time is safe.
  // target only
  always_ff @(posedge link_clk) begin
    if (local_rst) begin
      st <= tp_pkg::TP_D_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      acked <= 1'b0;
      ptr <= 16'h0000;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        st <= tp_pkg::TP_D_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st <= tp_pkg::TP_D_IDLE;
        sda_oe <= 1'b0;
      end else if (st != tp_pkg::TP_D_IDLE && scl_rise) begin
        cnt <= cnt + 4'h1;
        if (cnt < `TP_BIT_ACK) begin
          sh <= {sh[6:0], sda_ff[1]};
        end
        if (cnt == `TP_BIT_ACK) begin
          acked <= ~sda_ff[1];
        end
      end else if (st != tp_pkg::TP_D_IDLE && scl_fall) begin
        if (cnt == `TP_BIT_ACK) begin
          unique case (st)
            tp_pkg::TP_D_ADDR: begin
              if (sh[7:1] == own_addr) begin
                sda_oe <= 1'b1;
                rw <= sh[0];
              end else begin
                st <= tp_pkg::TP_D_IDLE;
              end
            end
            tp_pkg::TP_D_PHI: begin
              ptr[15:8] <= sh;
              sda_oe <= 1'b1;
            end
            tp_pkg::TP_D_PLO: begin
              ptr[7:0] <= sh;
              sda_oe <= 1'b1;
            end
            tp_pkg::TP_D_WDAT: begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= sh;
              sda_oe <= 1'b1;
            end
            tp_pkg::TP_D_RDAT: begin
              sda_oe <= 1'b0;
            end
            tp_pkg::TP_D_IDLE: begin
              sda_oe <= 1'b0;
            end
          endcase
        end else if (cnt == `TP_BIT_END) begin
          cnt <= 4'h0;
          sda_oe <= 1'b0;
          unique case (st)
            tp_pkg::TP_D_ADDR: begin
              if (rw) begin
                st <= tp_pkg::TP_D_RDAT;
                tx <= mem[ptr[7:0]];
                sda_oe <= ~mem[ptr[7:0]][7];
              end else begin
                st <= tp_pkg::TP_D_PHI;
              end
            end
            tp_pkg::TP_D_PHI: st <= tp_pkg::TP_D_PLO;
            tp_pkg::TP_D_PLO: st <= tp_pkg::TP_D_WDAT;
            tp_pkg::TP_D_WDAT: ptr <= ptr + 16'h0001;
            tp_pkg::TP_D_RDAT: begin
              ptr <= ptr + 16'h0001;
              if (acked) begin
                tx <= mem[8'(ptr[7:0] + 8'h01)];
                sda_oe <= ~mem[8'(ptr[7:0] + 8'h01)][7];
              end else begin
                st <= tp_pkg::TP_D_IDLE;
              end
            end
            tp_pkg::TP_D_IDLE: st <= tp_pkg::TP_D_IDLE;
          endcase
        end else if (st == tp_pkg::TP_D_RDAT && cnt != 4'h0) begin
          tx <= {tx[6:0], 1'b0};
          sda_oe <= ~tx[6];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bytes; only the low pointer byte selects a location, so the
  // space wraps every 256 bytes.
  always_ff @(posedge link_clk) begin
    if (wr_stb) begin
      mem[wr_addr[7:0]] <= wr_data;
    end
  end
endmodule

// ==== dv/tp_link_monitor.sv ====
// Concurrent checks on the two-wire link between the host end and the touch controller end.
module tp_link_monitor (
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic touch_rst_n,
  input wire logic int_line,
  input wire logic host_int_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_int_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_q;
  logic sda_q;
  logic trst_q;
  logic sel;
  logic dir;
  logic hit;
  logic [7:0] shreg;
  logic [7:0] cnt;
  logic scl_rise;
  logic start_c;
  logic stop_c;
  logic [6:0] exp_addr;
  assign scl_rise = scl && !scl_q;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c = scl && scl_q && !sda_q && sda;
  assign exp_addr = sel ? 7'h14 : 7'h5d;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    trst_q <= touch_rst_n;
    if (scl_rise) begin
      shreg <= {shreg[6:0], sda};
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel <= 1'b0;
    end else if (touch_rst_n && !trst_q) begin
      sel <= int_line;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 8'h01;
    end else if (start_c) begin
      cnt <= 8'h00;
    end else if (scl_rise) begin
      cnt <= cnt + 8'h01;
    end
  end
  // Direction and match of the address byte, known at its ninth clock.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir <= 1'b0;
      hit <= 1'b0;
    end else if (scl_rise && cnt == 8'h08) begin
      dir <= shreg[0];
      hit <= shreg[7:1] == exp_addr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    start_c;
  endsequence
  sequence s_host_nack;
    scl_rise && cnt > 8'h08 && cnt % 8'h09 == 8'h08 && hit && dir && sda;
  endsequence
  sequence s_dev_quiet;
    ##24 (!dev_sda_oe) [*8];
  endsequence
  property p_start_hold;
    @(posedge core_clk) disable iff (rst) s_start |=> scl [*8] ##[1:22] !scl;
  endproperty
  property p_stop_idle;
    @(posedge core_clk) disable iff (rst) stop_c |=> (scl && sda) [*8];
  endproperty
  property p_frame_bits;
    @(posedge core_clk) disable iff (rst) stop_c |-> cnt % 8'h09 == 8'h01;
  endproperty
  property p_addr_ack;
    @(posedge core_clk) disable iff (rst)
      scl_rise && cnt == 8'h08 |-> sda == (shreg[7:1] != exp_addr);
  endproperty
  property p_wr_ack;
    @(posedge core_clk) disable iff (rst)
      scl_rise && cnt > 8'h08 && cnt % 8'h09 == 8'h08 && hit && !dir |-> !sda;
  endproperty
  property p_nack_release;
    @(posedge core_clk) disable iff (rst) s_host_nack |-> s_dev_quiet;
  endproperty
  property p_dev_hold;
    @(posedge core_clk) disable iff (rst) $rose(scl) && dev_sda_oe |=> dev_sda_oe [*8];
  endproperty
  property p_dev_edge;
    @(posedge link_clk) disable iff (rst) $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_rst_quiet;
    @(posedge link_clk) disable iff (rst) (!touch_rst_n) [*6] |-> !dev_sda_oe && !dev_int_oe;
  endproperty
  property p_sel_hold;
    @(posedge core_clk) disable iff (rst) $rose(touch_rst_n) |-> host_int_oe [*8];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not followed by clock");
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  a_frame_bits: assert property (p_frame_bits) else $error("frame not whole bytes");
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  a_nack_release: assert property (p_nack_release) else $error("data held after nack");
  a_dev_hold: assert property (p_dev_hold) else $error("device data changed high");
  a_dev_edge: assert property (p_dev_edge) else $error("device drive changed high");
  a_rst_quiet: assert property (p_rst_quiet) else $error("device drives in reset");
  a_sel_hold: assert property (p_sel_hold) else $error("choice not held");
endmodule

// ==== dv/tb_touch_i2c_register_slave.sv ====
// Testbench joining the host end and the touch controller end over the link.
module tb_touch_i2c_register_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic link_clk;
  logic rst;
  logic addr_alt;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_rd;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_len;
  logic [7:0] wr_data;
  logic wr_take;
  logic rd_valid;
  logic [7:0] rd_data;
  logic done;
  logic nack_err;
  logic touch_int;
  logic touch_evt;
  logic wr_stb;
  logic [15:0] wr_addr;
  logic [7:0] dev_wr_data;
  logic [6:0] own_addr;
  logic evt_pend;
  logic [7:0] wbuf [4];
  logic [23:0] wq [$];
  logic [7:0] rq [$];
  int widx;
  int cycles;
  int failures;
  int checks;
  tp_i2c_if tp_i2c_if_i ();
  tp_host tp_host_i (.core_clk(core_clk), .rst(rst), .bus(tp_i2c_if_i.host),
    .addr_alt(addr_alt), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err),
    .touch_int(touch_int));
  tp_dev tp_dev_i (.link_clk(link_clk), .rst(rst), .bus(tp_i2c_if_i.dev),
    .touch_evt(touch_evt), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(dev_wr_data),
    .own_addr(own_addr), .evt_pend(evt_pend));
  tp_link_monitor tp_link_monitor_i (.core_clk(core_clk), .link_clk(link_clk), .rst(rst),
    .scl(tp_i2c_if_i.scl), .sda(tp_i2c_if_i.sda), .touch_rst_n(tp_i2c_if_i.touch_rst_n),
    .int_line(tp_i2c_if_i.int_line), .host_int_oe(tp_i2c_if_i.host_int_oe),
    .dev_sda_oe(tp_i2c_if_i.dev_sda_oe), .dev_int_oe(tp_i2c_if_i.dev_int_oe));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // The link clock starts off phase, so only one link clock edge in 25 lines up with a core clock edge.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures = failures + 1;
      $display("ERROR %0t: run did not finish", $time);
      close_out();
    end
  end
  always @(posedge core_clk) begin
    if (wr_take) begin
      widx <= widx + 1;
      wr_data <= wbuf[(widx + 1) % 4];
    end
  end
  always @(negedge core_clk) begin
    if (rd_valid) begin
      rq.push_back(rd_data);
    end
  end
  always @(negedge link_clk) begin
    if (wr_stb) begin
      wq.push_back({wr_addr, dev_wr_data});
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Samples on the falling edge, where the registered flags have settled.
  task automatic wait_high(ref logic sig, input int lim, input string what);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (sig !== 1'b1 && n < lim);
    chk(24'(sig), 24'h000001, what);
  endtask
  task automatic run(input logic rd, input logic [15:0] a, input logic [7:0] len);
    wait_high(cmd_ready, 4000, "ready");
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_rd <= rd;
    cmd_addr <= a;
    cmd_len <= len;
    wr_data <= wbuf[0];
    widx <= 0;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    wait_high(done, 20000, "done");
  endtask
  task automatic do_reset(input logic alt);
    @(posedge core_clk);
    addr_alt <= alt;
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wait_high(cmd_ready, 400, "ready after reset");
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    addr_alt = 1'b0;
    cmd_valid = 1'b0;
    cmd_rd = 1'b0;
    cmd_addr = 16'h0000;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    touch_evt = 1'b0;
    widx = 0;
    cycles = 0;
    failures = 0;
    checks = 0;
    wbuf = '{8'h3c, 8'ha5, 8'h0f, 8'hc3};
    do_reset(1'b0);
    chk(24'(own_addr), 24'h00005d, "own address");
    run(1'b0, 16'h12fe, 8'h04);
    chk(24'(nack_err), 24'h000000, "write refused");
    chk(24'(wq.size()), 24'h000004, "write count");
    for (int i = 0; i < 4; i++) begin
      chk(wq[i], {16'h12fe + 16'(i), wbuf[i]}, "written byte");
    end
    @(posedge link_clk);
    touch_evt <= 1'b1;
    @(posedge link_clk);
    touch_evt <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk(24'(evt_pend), 24'h000001, "event pending");
    chk(24'(touch_int), 24'h000001, "event line set");
    rq.delete();
    run(1'b1, 16'h12fe, 8'h04);
    chk(24'(rq.size()), 24'h000004, "read count");
    for (int i = 0; i < 4; i++) begin
      chk(24'(rq[i]), 24'(wbuf[i]), "read byte");
    end
    chk(24'(evt_pend), 24'h000000, "event cleared");
    repeat (10) @(negedge core_clk);
    chk(24'(touch_int), 24'h000000, "event line clear");
    @(posedge core_clk);
    addr_alt <= 1'b1;
    wq.delete();
    run(1'b0, 16'h0040, 8'h01);
    chk(24'(nack_err), 24'h000001, "foreign address");
    chk(24'(wq.size()), 24'h000000, "foreign write");
    @(posedge core_clk);
    addr_alt <= 1'b0;
    rq.delete();
    run(1'b1, 16'h12ff, 8'h01);
    chk(24'(rq.size()), 24'h000001, "single read count");
    chk(24'(rq[0]), 24'(wbuf[1]), "single read byte");
    chk(24'(nack_err), 24'h000000, "error cleared");
    do_reset(1'b1);
    chk(24'(own_addr), 24'h000014, "alternate address");
    wbuf[0] = 8'h5a;
    wq.delete();
    run(1'b0, 16'h0007, 8'h01);
    chk(wq[0], 24'h00075a, "alternate write");
    rq.delete();
    run(1'b1, 16'h0007, 8'h01);
    chk(24'(rq[0]), 24'h00005a, "alternate read");
    close_out();
  end
endmodule
